// *** hdl/ccf_pkg.sv ***
// constants for the processor control flag block
package ccf_pkg;

  // =====================================================
  // control register selectors
  localparam logic [2:0] SEL_SYS = 3'h0;
  localparam logic [2:0] SEL_DIR = 3'h3;
  localparam logic [2:0] SEL_EXT = 3'h4;

  // =====================================================
  // system_control_word bit positions
  localparam int SYS_PROT = 0;
  localparam int SYS_WMON = 1;
  localparam int SYS_NOFPU = 2;
  localparam int SYS_FPUSW = 3;
  localparam int SYS_EXTT = 4;
  localparam int SYS_CACHEOFF = 30;
  localparam int SYS_PAGING = 31;
  // stored bits; extension type reads as a fixed one
  localparam logic [31:0] SYS_WMASK = 32'hE005002F;
  localparam logic [31:0] SYS_FIXED = 32'h00000010;
  localparam logic [31:0] SYS_RESET = 32'h00000000;

  // =====================================================
  // page_directory_base bit positions
  localparam int DIR_WTHRU = 3;
  localparam int DIR_CACHEOFF = 4;
  localparam logic [31:0] DIR_WMASK = 32'hFFFFF018;
  localparam logic [31:0] DIR_RESET = 32'h00000000;

  // =====================================================
  // extension_enable_word bit positions
  localparam int EXT_V86 = 0;
  localparam int EXT_PVIRQ = 1;
  localparam int EXT_TSLOCK = 2;
  localparam int EXT_DBGBLK = 3;
  localparam int EXT_LPAGE = 4;
  localparam int EXT_WPHYS = 5;
  localparam int EXT_MCHK = 6;
  localparam int EXT_GPAGE = 7;
  localparam int EXT_PCREAD = 8;
  localparam int EXT_W = 9;
  localparam logic [31:0] EXT_RESET = 32'h00000000;

  // =====================================================
  // privilege
  localparam logic [1:0] CPL_KERNEL = 2'h0;

endpackage

// *** hdl/ccf_op_check.sv ***
// instruction gate: decodes control flags into faults per opcode class
`timescale 1ns/1ps
`default_nettype none

module ccf_op_check (
  // flags
  input  wire logic       i_no_fpu,
  input  wire logic       i_wait_mon,
  input  wire logic       i_fpu_sw,
  input  wire logic       i_tstamp_lock,
  input  wire logic       i_dbg_block,
  input  wire logic       i_pc_read,
  input  wire logic [1:0] i_cpl,
  // instruction classes
  input  wire logic       i_fp_op,
  input  wire logic       i_wait_op,
  input  wire logic       i_tsc_op,
  input  wire logic       i_pmc_op,
  input  wire logic       i_dbg45_op,
  // verdict
  output logic            o_unavail,
  output logic            o_badop,
  output logic            o_protflt,
  output logic            o_ok
);

  wire logic kernel;
  wire logic fp_trap;
  wire logic wait_trap;
  wire logic any_op;

  assign kernel    = (i_cpl == ccf_pkg::CPL_KERNEL);
  // monitor flag decides whether wait looks at the switched flag
  assign fp_trap   = i_fp_op & (i_no_fpu | i_fpu_sw);
  assign wait_trap = i_wait_op & i_wait_mon & i_fpu_sw;
  assign any_op    = i_fp_op | i_wait_op | i_tsc_op | i_pmc_op | i_dbg45_op;

  assign o_unavail = fp_trap | wait_trap;
  assign o_badop   = i_dbg45_op & i_dbg_block;
  assign o_protflt = (i_tsc_op & i_tstamp_lock & ~kernel)
                   | (i_pmc_op & ~i_pc_read & ~kernel);
  assign o_ok = any_op & ~o_unavail & ~o_badop & ~o_protflt;

endmodule

`default_nettype wire

// *** hdl/ccf_ctrl_flags.sv ***
// control flag registers, move access and fault reporting
//
// Functional notes
// - fp op faults unavailable if no-fpu or switched flag set, else runs.
// - wait op faults only when monitor and switched flags both set.
// - no-fpu flag is bit 2 of system word; traps every fp op.
// - monitor flag bit 1; when clear wait ignores switched flag.
// - protection flag bit 0; protected versus real mode, paging needs both.
// - directory cache-off flag bit 4 of directory base.
// - directory write-through flag bit 3; write-through when set else write-back.
// - both directory cache flags ignored unless paging on and cache on.
// - v86 extensions enable at bit 0 of extension word.
// - protected virtual irq support enable at bit 1.
// - timestamp read locked to level zero when bit 2 set.
// - debug alias block at bit 3; regs four, five give bad opcode.
// - large page enable at bit 4.
// - wide physical address enable at bit 5.
// - machine check enable at bit 6.
// - global page enable at bit 7.
// - perf counter read at any level when bit 8 set.
// - identify reports implemented extension flags except perf counter flag.
// - control register loads only at privilege level zero.
// - switched flag bit 3 set on every task switch; tested by fp ops.
// - setting paging with protection clear raises protection fault.
`timescale 1ns/1ps
`default_nettype none

module ccf_ctrl_flags #(
  // extension flags this model implements; arbitrary default, all present
  parameter logic [8:0] EXT_IMPL = 9'h1FF
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // move to / from control register
  input  wire logic        i_cr_wr,
  input  wire logic        i_cr_rd,
  input  wire logic [2:0]  i_cr_sel,
  input  wire logic [31:0] i_cr_wdata,
  input  wire logic [1:0]  i_cpl,
  // task switch and clear of the switched flag
  input  wire logic        i_task_switch,
  input  wire logic        i_clr_fpu_sw,
  // instruction classes to gate
  input  wire logic        i_fp_op,
  input  wire logic        i_wait_op,
  input  wire logic        i_tsc_op,
  input  wire logic        i_pmc_op,
  input  wire logic        i_dbg45_op,
  input  wire logic        i_identify_op,
  // read answer
  output logic             o_rd_valid,
  output logic [31:0]      o_rd_data,
  // verdicts
  output logic             o_dev_unavail_fault,
  output logic             o_bad_opcode_fault,
  output logic             o_gen_prot_fault,
  output logic             o_op_exec,
  // identify answer
  output logic             o_ident_valid,
  output logic [8:0]       o_ident_features,
  // flags to the consuming units
  output logic             o_protect_on,
  output logic             o_paging_on,
  output logic             o_dir_cache_off,
  output logic             o_dir_write_through,
  output logic             o_v86_ext,
  output logic             o_prot_virq,
  output logic             o_large_page,
  output logic             o_wide_phys,
  output logic             o_mc_enable,
  output logic             o_global_page
);

  // =====================================================
  // stored words
  logic [31:0] sys_word;
  logic [31:0] dir_word;
  logic [8:0]  ext_word;

  // =====================================================
  // write qualification
  wire logic        kernel;
  wire logic        sel_sys;
  wire logic        sel_dir;
  wire logic        sel_ext;
  wire logic        sel_ok;
  wire logic        wr_priv_bad;
  wire logic        wr_page_bad;
  wire logic        wr_rsv_bad;
  wire logic        wr_protflt;
  wire logic        wr_badop;
  wire logic        wr_ok;
  wire logic        clr_ok;
  wire logic        clr_protflt;
  wire logic [31:0] ext_impl32;

  assign kernel      = (i_cpl == ccf_pkg::CPL_KERNEL);
  assign sel_sys     = (i_cr_sel == ccf_pkg::SEL_SYS);
  assign sel_dir     = (i_cr_sel == ccf_pkg::SEL_DIR);
  assign sel_ext     = (i_cr_sel == ccf_pkg::SEL_EXT);
  assign sel_ok      = sel_sys | sel_dir | sel_ext;
  assign ext_impl32  = {23'h000000, EXT_IMPL};
  assign wr_priv_bad = i_cr_wr & sel_ok & ~kernel;
  assign wr_page_bad = i_cr_wr & sel_sys
                     & i_cr_wdata[ccf_pkg::SYS_PAGING]
                     & ~i_cr_wdata[ccf_pkg::SYS_PROT];
  // an unimplemented extension bit must not be set by software
  assign wr_rsv_bad  = i_cr_wr & sel_ext & |(i_cr_wdata & ~ext_impl32);
  assign wr_protflt  = wr_priv_bad | wr_page_bad | wr_rsv_bad;
  assign wr_badop    = i_cr_wr & ~sel_ok;
  assign wr_ok       = i_cr_wr & sel_ok & ~wr_protflt;
  assign clr_ok      = i_clr_fpu_sw & kernel;
  assign clr_protflt = i_clr_fpu_sw & ~kernel;

  // =====================================================
  // next values
  wire logic [31:0] sys_wr_val;
  wire logic [31:0] next_sys;
  wire logic [31:0] next_dir;
  wire logic [8:0]  next_ext;
  wire logic        next_fpu_sw;

  assign sys_wr_val = (wr_ok & sel_sys)
                    ? ((i_cr_wdata & ccf_pkg::SYS_WMASK)
                       | (sys_word & ~ccf_pkg::SYS_WMASK))
                    : sys_word;
  // a task switch in the same cycle as a clear leaves the flag set
  assign next_fpu_sw = i_task_switch
                     | (sys_wr_val[ccf_pkg::SYS_FPUSW] & ~clr_ok);
  assign next_sys = {sys_wr_val[31:ccf_pkg::SYS_FPUSW + 1],
                     next_fpu_sw,
                     sys_wr_val[ccf_pkg::SYS_FPUSW - 1:0]};
  assign next_dir = (wr_ok & sel_dir)
                  ? (i_cr_wdata & ccf_pkg::DIR_WMASK) : dir_word;
  assign next_ext = (wr_ok & sel_ext)
                  ? i_cr_wdata[ccf_pkg::EXT_W - 1:0] : ext_word;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sys_word <= ccf_pkg::SYS_RESET;
      dir_word <= ccf_pkg::DIR_RESET;
      ext_word <= ccf_pkg::EXT_RESET[ccf_pkg::EXT_W - 1:0];
    end else begin
      sys_word <= next_sys;
      dir_word <= next_dir;
      ext_word <= next_ext;
    end
  end

  // =====================================================
  // read path
  wire logic [31:0] rd_mux;

  assign rd_mux = sel_sys ? (sys_word | ccf_pkg::SYS_FIXED)
                : sel_dir ? dir_word
                : sel_ext ? {23'h000000, ext_word}
                : 32'h00000000;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 32'h00000000;
    end else begin
      o_rd_valid <= i_cr_rd & sel_ok;
      o_rd_data  <= (i_cr_rd & sel_ok) ? rd_mux : 32'h00000000;
    end
  end

  // =====================================================
  // instruction gate
  wire logic op_unavail;
  wire logic op_badop;
  wire logic op_protflt;
  wire logic op_ok;

  ccf_op_check u_op_check (
    .i_no_fpu    (sys_word[ccf_pkg::SYS_NOFPU]),
    .i_wait_mon  (sys_word[ccf_pkg::SYS_WMON]),
    .i_fpu_sw    (sys_word[ccf_pkg::SYS_FPUSW]),
    .i_tstamp_lock (ext_word[ccf_pkg::EXT_TSLOCK]),
    .i_dbg_block (ext_word[ccf_pkg::EXT_DBGBLK]),
    .i_pc_read   (ext_word[ccf_pkg::EXT_PCREAD]),
    .i_cpl       (i_cpl),
    .i_fp_op     (i_fp_op),
    .i_wait_op   (i_wait_op),
    .i_tsc_op    (i_tsc_op),
    .i_pmc_op    (i_pmc_op),
    .i_dbg45_op  (i_dbg45_op),
    .o_unavail   (op_unavail),
    .o_badop     (op_badop),
    .o_protflt   (op_protflt),
    .o_ok        (op_ok)
  );

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_dev_unavail_fault <= 1'b0;
      o_bad_opcode_fault  <= 1'b0;
      o_gen_prot_fault    <= 1'b0;
      o_op_exec           <= 1'b0;
    end else begin
      o_dev_unavail_fault <= op_unavail;
      o_bad_opcode_fault  <= op_badop | wr_badop;
      o_gen_prot_fault    <= op_protflt | wr_protflt | clr_protflt;
      o_op_exec           <= op_ok;
    end
  end

  // =====================================================
  // identify answer; the perf counter flag is never reported
  wire logic [8:0] ident_mask;

  assign ident_mask = EXT_IMPL & ~(9'h001 << ccf_pkg::EXT_PCREAD);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ident_valid    <= 1'b0;
      o_ident_features <= 9'h000;
    end else begin
      o_ident_valid    <= i_identify_op;
      o_ident_features <= i_identify_op ? ident_mask : 9'h000;
    end
  end

  // =====================================================
  // flags to consumers, taken from next values so they line up
  // with the stored words and lag no further
  wire logic dir_flags_live;

  assign dir_flags_live = next_sys[ccf_pkg::SYS_PAGING]
                        & next_sys[ccf_pkg::SYS_PROT]
                        & ~next_sys[ccf_pkg::SYS_CACHEOFF];

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_protect_on        <= 1'b0;
      o_paging_on         <= 1'b0;
      o_dir_cache_off     <= 1'b0;
      o_dir_write_through <= 1'b0;
      o_v86_ext           <= 1'b0;
      o_prot_virq         <= 1'b0;
      o_large_page        <= 1'b0;
      o_wide_phys         <= 1'b0;
      o_mc_enable         <= 1'b0;
      o_global_page       <= 1'b0;
    end else begin
      o_protect_on        <= next_sys[ccf_pkg::SYS_PROT];
      o_paging_on         <= next_sys[ccf_pkg::SYS_PAGING]
                           & next_sys[ccf_pkg::SYS_PROT];
      o_dir_cache_off     <= dir_flags_live
                           & next_dir[ccf_pkg::DIR_CACHEOFF];
      o_dir_write_through <= dir_flags_live
                           & next_dir[ccf_pkg::DIR_WTHRU];
      o_v86_ext           <= next_ext[ccf_pkg::EXT_V86];
      o_prot_virq         <= next_ext[ccf_pkg::EXT_PVIRQ];
      o_large_page        <= next_ext[ccf_pkg::EXT_LPAGE];
      o_wide_phys         <= next_ext[ccf_pkg::EXT_WPHYS];
      o_mc_enable         <= next_ext[ccf_pkg::EXT_MCHK];
      o_global_page       <= next_ext[ccf_pkg::EXT_GPAGE];
    end
  end

  // =====================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_switch;
    i_task_switch;
  endsequence

  sequence s_fp_after;
    i_fp_op & ~i_cr_wr;
  endsequence

  chk_fp_trap_table: assert property (
    i_fp_op & ~i_wait_op |=> o_dev_unavail_fault ==
      ($past(sys_word[ccf_pkg::SYS_NOFPU])
       | $past(sys_word[ccf_pkg::SYS_FPUSW])))
    else $error("fp fault does not follow the flags");

  chk_wait_trap_table: assert property (
    i_wait_op & ~i_fp_op |=> o_dev_unavail_fault ==
      ($past(sys_word[ccf_pkg::SYS_WMON])
       & $past(sys_word[ccf_pkg::SYS_FPUSW])))
    else $error("wait fault does not follow the flags");

  chk_switch_then_fp: assert property (
    s_switch ##1 s_fp_after |=> o_dev_unavail_fault)
    else $error("fp op after task switch not trapped");

  chk_switch_beats_clear: assert property (
    i_task_switch & i_clr_fpu_sw |=> sys_word[ccf_pkg::SYS_FPUSW])
    else $error("clear won over task switch");

  chk_user_write_blocked: assert property (
    i_cr_wr & sel_ok & ~kernel & ~i_task_switch |=>
      o_gen_prot_fault && $stable(sys_word) && $stable(dir_word)
      && $stable(ext_word))
    else $error("user level changed a control register");

  chk_paging_needs_prot: assert property (
    wr_page_bad |=> o_gen_prot_fault
      && (o_paging_on == $past(o_paging_on)))
    else $error("paging set without protection accepted");

  chk_dir_flags_gated: assert property (
    ~o_paging_on | sys_word[ccf_pkg::SYS_CACHEOFF] |->
      ~o_dir_cache_off & ~o_dir_write_through)
    else $error("directory cache flags leak through");

  chk_tsc_lock: assert property (
    i_tsc_op & ext_word[ccf_pkg::EXT_TSLOCK] & ~kernel |=>
      o_gen_prot_fault & ~o_op_exec)
    else $error("locked timestamp read allowed at user level");

  chk_pmc_open: assert property (
    i_pmc_op & ~i_fp_op & ~i_wait_op & ~i_tsc_op & ~i_dbg45_op
      & ~i_cr_wr & ~i_clr_fpu_sw & ext_word[ccf_pkg::EXT_PCREAD]
      |=> o_op_exec & ~o_gen_prot_fault)
    else $error("open perf counter read refused");

  chk_dbg_alias: assert property (
    i_dbg45_op |=> o_bad_opcode_fault ==
      ($past(ext_word[ccf_pkg::EXT_DBGBLK]) | $past(wr_badop)))
    else $error("debug alias fault wrong");

  chk_write_readback: assert property (
    wr_ok & sel_ext & ~i_task_switch ##1 i_cr_rd & sel_ext & ~i_cr_wr
      |=> o_rd_data[8:0] == $past(i_cr_wdata[8:0], 2))
    else $error("read does not return the written flags");

  chk_ident_mask: assert property (
    i_identify_op |=>
      o_ident_valid & ~o_ident_features[ccf_pkg::EXT_PCREAD])
    else $error("identify reports perf counter flag");

endmodule

`default_nettype wire

// *** dv/ccf_ctrl_flags_tb.sv ***
// self-checking testbench for the control flag registers and fault gate
`timescale 1ns/1ps
`default_nettype none

module ccf_ctrl_flags_tb;
  // ==========================================================
  // stimulus and observation
  logic        i_mclk;
  logic        i_sys_rst;
  logic        i_cr_wr;
  logic        i_cr_rd;
  logic [2:0]  i_cr_sel;
  logic [31:0] i_cr_wdata;
  logic [1:0]  i_cpl;
  logic        i_task_switch;
  logic        i_clr_fpu_sw;
  logic        i_identify_op;
  logic [4:0]  ops;
  logic        o_rd_valid;
  logic [31:0] o_rd_data;
  logic        o_unavail;
  logic        o_badop;
  logic        o_protflt;
  logic        o_exec;
  logic        o_ident_valid;
  logic [8:0]  o_ident_features;
  logic        o_protect_on;
  logic        o_paging_on;
  logic        o_dcoff;
  logic        o_dwt;
  logic [8:0]  fo;
  logic [3:0]  verdict;
  int          miscompares;
  int          checked;

  ccf_ctrl_flags i_ccf_ctrl_flags (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cr_wr(i_cr_wr),
    .i_cr_rd(i_cr_rd), .i_cr_sel(i_cr_sel), .i_cr_wdata(i_cr_wdata),
    .i_cpl(i_cpl), .i_task_switch(i_task_switch),
    .i_clr_fpu_sw(i_clr_fpu_sw), .i_fp_op(ops[0]), .i_wait_op(ops[1]),
    .i_tsc_op(ops[2]), .i_pmc_op(ops[3]), .i_dbg45_op(ops[4]),
    .i_identify_op(i_identify_op), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_dev_unavail_fault(o_unavail),
    .o_bad_opcode_fault(o_badop), .o_gen_prot_fault(o_protflt),
    .o_op_exec(o_exec),
    .o_ident_valid(o_ident_valid), .o_ident_features(o_ident_features),
    .o_protect_on(o_protect_on), .o_paging_on(o_paging_on),
    .o_dir_cache_off(o_dcoff), .o_dir_write_through(o_dwt),
    .o_v86_ext(fo[0]), .o_prot_virq(fo[1]), .o_large_page(fo[4]),
    .o_wide_phys(fo[5]), .o_mc_enable(fo[6]), .o_global_page(fo[7])
  );
  // ext bits 2, 3 and 8 gate ops only and have no level output
  assign fo[3:2] = 2'h0;
  assign fo[8] = 1'h0;
  assign verdict = {o_unavail, o_badop, o_protflt, o_exec};

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // shared tasks; all start and end at a falling edge
  // strobes stay up until the next driver sets them, so no signal is
  // assigned twice in one time step between back to back transfers
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [31:0] d,
                    input logic [1:0] c, input logic [3:0] e);
    i_cr_wr = 1'b1;
    i_cr_rd = 1'b0;
    ops = 5'h00;
    i_cr_sel = sel;
    i_cr_wdata = d;
    i_cpl = c;
    @(negedge i_mclk);
    chk("write verdict", 32'(verdict), 32'(e));
  endtask

  task automatic rd(input logic [2:0] sel, input logic [31:0] e);
    i_cr_rd = 1'b1;
    i_cr_wr = 1'b0;
    ops = 5'h00;
    i_cr_sel = sel;
    @(negedge i_mclk);
    chk("read valid", 32'(o_rd_valid), 32'h1);
    chk("read data", o_rd_data, e);
  endtask

  task automatic op(input logic [4:0] o, input logic [1:0] c,
                    input logic [3:0] e);
    ops = o;
    i_cr_wr = 1'b0;
    i_cr_rd = 1'b0;
    i_cpl = c;
    @(negedge i_mclk);
    chk("op verdict", 32'(verdict), 32'(e));
  endtask

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(ccf_pkg::SEL_SYS, 32'h00000010);
    rd(ccf_pkg::SEL_DIR, 32'h00000000);
    rd(ccf_pkg::SEL_EXT, 32'h00000000);
    $display("reset values done");
  endtask

  task automatic t_fpu_table;
    logic nofpu, wmon, fsw;
    for (int k = 0; k < 8; k++) begin
      {nofpu, wmon, fsw} = k[2:0];
      wr(ccf_pkg::SEL_SYS, {28'h0, fsw, nofpu, wmon, 1'b0}, 2'h0, 4'h0);
      rd(ccf_pkg::SEL_SYS, {28'h1, fsw, nofpu, wmon, 1'b0});
      op(5'h01, 2'h0, (nofpu | fsw) ? 4'h8 : 4'h1);
      op(5'h02, 2'h0, (wmon & fsw) ? 4'h8 : 4'h1);
    end
    $display("fpu flag table done");
  endtask

  task automatic t_task_switch;
    wr(ccf_pkg::SEL_SYS, 32'h0, 2'h0, 4'h0);
    i_cr_wr = 1'b0;
    i_task_switch = 1'b1;
    i_clr_fpu_sw = 1'b1;
    @(negedge i_mclk);
    i_task_switch = 1'b0;
    i_clr_fpu_sw = 1'b0;
    op(5'h01, 2'h0, 4'h8);
    op(5'h02, 2'h0, 4'h1);
    rd(ccf_pkg::SEL_SYS, 32'h00000018);
    i_cr_rd = 1'b0;
    i_clr_fpu_sw = 1'b1;
    i_cpl = 2'h3;
    @(negedge i_mclk);
    i_clr_fpu_sw = 1'b0;
    chk("clear verdict", 32'(o_protflt), 32'h1);
    op(5'h01, 2'h0, 4'h8);
    ops = 5'h00;
    i_clr_fpu_sw = 1'b1;
    @(negedge i_mclk);
    i_clr_fpu_sw = 1'b0;
    op(5'h01, 2'h0, 4'h1);
    $display("task switch done");
  endtask

  task automatic t_paging;
    wr(ccf_pkg::SEL_SYS, 32'h80000000, 2'h0, 4'h2);
    rd(ccf_pkg::SEL_SYS, 32'h00000010);
    wr(ccf_pkg::SEL_SYS, 32'h00000001, 2'h0, 4'h0);
    chk("mode", 32'({o_protect_on, o_paging_on}), 32'h2);
    wr(ccf_pkg::SEL_SYS, 32'h80000001, 2'h0, 4'h0);
    chk("mode", 32'({o_protect_on, o_paging_on}), 32'h3);
    wr(ccf_pkg::SEL_DIR, 32'h00000008, 2'h0, 4'h0);
    chk("dir flags", 32'({o_dcoff, o_dwt}), 32'h1);
    wr(ccf_pkg::SEL_DIR, 32'h00000010, 2'h0, 4'h0);
    chk("dir flags", 32'({o_dcoff, o_dwt}), 32'h2);
    wr(ccf_pkg::SEL_DIR, 32'h00000008, 2'h3, 4'h2);
    rd(ccf_pkg::SEL_DIR, 32'h00000010);
    wr(ccf_pkg::SEL_DIR, 32'h00000018, 2'h0, 4'h0);
    wr(ccf_pkg::SEL_SYS, 32'hC0000001, 2'h0, 4'h0);
    chk("dir flags", 32'({o_dcoff, o_dwt}), 32'h0);
    wr(ccf_pkg::SEL_SYS, 32'h00000001, 2'h0, 4'h0);
    chk("dir flags", 32'({o_dcoff, o_dwt}), 32'h0);
    rd(ccf_pkg::SEL_DIR, 32'h00000018);
    $display("paging and directory done");
  endtask

  task automatic t_ext;
    for (int b = 0; b < 9; b++) begin
      wr(ccf_pkg::SEL_EXT, 32'h1 << b, 2'h0, 4'h0);
      chk("ext levels", 32'(fo), (32'h1 << b) & 32'h0F3);
      rd(ccf_pkg::SEL_EXT, 32'h1 << b);
    end
    wr(ccf_pkg::SEL_EXT, 32'h0, 2'h0, 4'h0);
    op(5'h04, 2'h3, 4'h1);
    op(5'h08, 2'h3, 4'h2);
    op(5'h08, 2'h0, 4'h1);
    op(5'h10, 2'h3, 4'h1);
    wr(ccf_pkg::SEL_EXT, 32'h104, 2'h0, 4'h0);
    op(5'h04, 2'h3, 4'h2);
    op(5'h04, 2'h0, 4'h1);
    op(5'h08, 2'h3, 4'h1);
    wr(ccf_pkg::SEL_EXT, 32'h008, 2'h0, 4'h0);
    op(5'h10, 2'h0, 4'h4);
    wr(ccf_pkg::SEL_EXT, 32'h200, 2'h0, 4'h2);
    wr(ccf_pkg::SEL_EXT, 32'h001, 2'h3, 4'h2);
    rd(ccf_pkg::SEL_EXT, 32'h008);
    $display("extension flags done");
  endtask

  task automatic t_identify;
    i_cr_rd = 1'b0;
    i_identify_op = 1'b1;
    @(negedge i_mclk);
    i_identify_op = 1'b0;
    chk("ident valid", 32'(o_ident_valid), 32'h1);
    chk("ident features", 32'(o_ident_features), 32'h0FF);
    wr(3'h1, 32'h1, 2'h0, 4'h4);
    i_cr_wr = 1'b0;
    i_cr_rd = 1'b1;
    @(negedge i_mclk);
    i_cr_rd = 1'b0;
    chk("unmapped read", 32'(o_rd_valid), 32'h0);
    $display("identify and unmapped done");
  endtask

  // ==========================================================
  // sequence and watchdog
  initial begin
    miscompares = 0;
    checked = 0;
    i_sys_rst = 1'b1;
    {i_cr_wr, i_cr_rd, i_task_switch, i_clr_fpu_sw, i_identify_op} = 5'h00;
    i_cr_sel = 3'h0;
    i_cr_wdata = 32'h0;
    i_cpl = 2'h0;
    ops = 5'h00;
    repeat (16) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    @(negedge i_mclk);
    t_reset();
    t_fpu_table();
    t_task_switch();
    t_paging();
    t_ext();
    t_identify();
    end_sim();
  end

  // all tests need about 110 cycles; a hang is cut off well past that
  initial begin
    repeat (5000) @(posedge i_mclk);
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire
